// ===== rtl/fbs_ctrl.v
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "fbs_map.vh"
// How it works
// RULE1 - Upper select register is held zero while software write enable is zero.
// RULE2 - Two or more select bits set at once clears the whole register.
// RULE3 - Unused upper bits of both registers always read as zero.
// RULE4 - Software writes zeros to overlay bits five and four; they are stored.
// RULE5 - Bit one targets region 0x018000 to 0x01FFFF for erase.
// RULE6 - Bit zero targets region 0x010000 to 0x017FFF for erase.
// RULE7 - Overlay enable maps flash onto RAM and blocks all program and erase.
// RULE8 - Overlay maps the chosen 1-kbyte block at RAM 0xFFE000 to 0xFFE3FF.
// RULE9 - Area field from bits two and one picks block 0x000, 0x400, 0x800, 0xC00.
// RULE10 - Software writes the overlay register only in user or user program mode.
// RULE11 - Software avoids the emulated region right after changing the overlay.
// RULE12 - Mode pins and enable pin are stable four states before reset release.
// RULE13 - Reset end selects user mode on 1111 and boot mode on 0111.
// RULE14 - Boot mode runs the loader sequence, erasing all flash, then runs code.
// RULE15 - User program mode allows per-block erase and program; no pin pattern in the mode latch selects this mode.
// RULE16 - Program and erase allowed only while software write enable is one.
// RULE17 - Write enable pin level reads back as a read-only status bit.
// RULE18 - Decoded mode is latched at reset release and held until next reset.
// RULE19 - Both registers reset to all zeros.
module fbs_ctrl (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Mode pins and flash write enable pin.
  input wire mode_pin_two_i,
  input wire mode_pin_one_i,
  input wire mode_pin_zero_i,
  input wire flash_write_enable_pin_i,
  // Loader handshake: serial transfer done and erase done.
  input wire boot_load_done_i,
  input wire boot_erase_done_i,
  // Flash side: erase targets, overlay and protection.
  output reg erase_blk_nine_o,
  output reg erase_blk_eight_o,
  output reg [23:0] erase_lo_o,
  output reg [23:0] erase_hi_o,
  output reg pe_allow_o,
  output reg overlay_active_o,
  output reg [23:0] overlay_flash_base_o,
  output reg [23:0] overlay_ram_lo_o,
  output reg [23:0] overlay_ram_hi_o,
  output reg boot_erase_all_o,
  output reg boot_run_o,
  output reg [1:0] mode_o
);
  // Loader states.
  localparam BT_IDLE = 3'h0;
  localparam BT_WAIT = 3'h1;
  localparam BT_LOAD = 3'h2;
  localparam BT_ERASE = 3'h3;
  localparam BT_RUN = 3'h4;

  // Reset images of the two registers; only the stored bits are kept.
  localparam [7:0] UEBS_RST = `FBS_UEBS_RST;
  localparam [7:0] ROVL_RST = `FBS_ROVL_RST;

  // Register state, decoded strobes and read images.
  reg software_write_enable;
  reg [1:0] upper_erase_block_select;
  reg [5:0] ram_overlay_control;
  reg [2:0] bt_state;
  reg [2:0] next_bt_state;
  reg [7:0] bt_cnt;
  reg [1:0] next_uebs;
  reg [7:0] rd_byte;
  wire [1:0] mode;
  wire wr_lane;
  wire acc;
  wire ovl_write_ok;
  wire overlay_enable;
  wire overlay_area_bit_two;
  wire overlay_area_bit_one;
  wire wr_ctrl;
  wire wr_uebs;
  wire wr_rovl;
  wire loader_busy;
  wire [7:0] ctrl_rd;
  wire [7:0] uebs_rd;
  wire [7:0] rovl_rd;
  wire [7:0] stat_rd;

  // Flags a two-bit select field that has more than one bit set.
  function more_than_one;
    input [1:0] v;
    begin
      more_than_one = v[1] & v[0];
    end
  endfunction

  // User and user program mode are the modes in which software owns the flash;
  // boot mode and an unknown pin pattern leave it locked.
  function mode_writable;
    input [1:0] m;
    begin
      mode_writable = (m == `FBS_MODE_USER) || (m == `FBS_MODE_UPGM);
    end
  endfunction

  // Lowest address of the region picked by the upper select; zero when none is
  // picked, so the flash side never sees a stale region.
  function [23:0] region_lo;
    input [1:0] sel;
    begin
      if (sel[`FBS_UEBS_NINE]) begin
        region_lo = `FBS_NINE_LO; // RULE5
      end else if (sel[`FBS_UEBS_EIGHT]) begin
        region_lo = `FBS_EIGHT_LO; // RULE6
      end else begin
        region_lo = 24'h000000;
      end
    end
  endfunction

  // Highest address of the region picked by the upper select; zero when none.
  function [23:0] region_hi;
    input [1:0] sel;
    begin
      if (sel[`FBS_UEBS_NINE]) begin
        region_hi = `FBS_NINE_HI; // RULE5
      end else if (sel[`FBS_UEBS_EIGHT]) begin
        region_hi = `FBS_EIGHT_HI; // RULE6
      end else begin
        region_hi = 24'h000000;
      end
    end
  endfunction

  // Flash base of the overlaid block. The area field counts whole 1-kbyte blocks,
  // so the base only ever has bits eleven and ten set.
  function [23:0] area_base;
    input [1:0] area;
    begin
      area_base = {22'h0, area} * `FBS_OVL_STEP; // RULE9
    end
  endfunction

  // Operating mode, caught once as reset ends and held until the next reset;
  // later changes on the mode pins have no effect.
  fbs_mode_latch u_mode (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_pin_two_i(mode_pin_two_i),
    .mode_pin_one_i(mode_pin_one_i),
    .mode_pin_zero_i(mode_pin_zero_i),
    .flash_write_enable_pin_i(flash_write_enable_pin_i),
    .mode_o(mode)
  );

  // Bus access decode. A request counts only while no ack stands, and only the low
  // byte lane carries register data.
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane = acc & wb_we_i & wb_sel_i[0];
  assign ovl_write_ok = mode_writable(mode);
  assign overlay_enable = ram_overlay_control[`FBS_ROVL_EN];
  assign overlay_area_bit_two = ram_overlay_control[`FBS_ROVL_AREA_HI];
  assign overlay_area_bit_one = ram_overlay_control[`FBS_ROVL_AREA_LO];
  // Bit zero of the overlay register is stored but plays no part in the mapping.

  // One write strobe per register; overlay writes outside the owning modes fall away.
  assign wr_ctrl = wr_lane && (wb_adr_i == `FBS_ADR_CTRL);
  assign wr_uebs = wr_lane && (wb_adr_i == `FBS_ADR_UEBS);
  assign wr_rovl = wr_lane && (wb_adr_i == `FBS_ADR_ROVL) && ovl_write_ok; // RULE10

  // The loader is busy from its start-up wait until the erase is finished.
  assign loader_busy = (bt_state != BT_IDLE) && (bt_state != BT_RUN);

  // Read images; unused upper bits are tied to zero.
  assign ctrl_rd = {7'h00, software_write_enable};
  assign uebs_rd = {6'h00, upper_erase_block_select}; // RULE3
  assign rovl_rd = {2'h0, ram_overlay_control}; // RULE3
  // Status: bit zero pin level, bits two and one mode, bit three overlay, bit four busy.
  assign stat_rd = {3'h0, loader_busy, overlay_enable, mode, flash_write_enable_pin_i}; // RULE17

  // Next upper select value: a write first, then the multi-bit clear, and last the
  // enable clear, so a write made while the enable is low can never stick.
  always @* begin
    next_uebs = upper_erase_block_select;
    if (wr_uebs) begin
      next_uebs = wb_dat_i[1:0];
    end
    if (more_than_one(next_uebs)) begin // RULE2
      next_uebs = 2'h0;
    end
    if (!software_write_enable) begin // RULE1 RULE16
      next_uebs = 2'h0;
    end
  end

  // Control, select and overlay registers. Overlay bits five and four are kept as
  // written, so software must write zeros there; bits seven and six are not stored
  // at all and cannot leak into the mapping.
  always @(posedge clk_i) begin
    if (rst_i) begin
      software_write_enable <= 1'b0;
      upper_erase_block_select <= UEBS_RST[1:0]; // RULE19
      ram_overlay_control <= ROVL_RST[5:0]; // RULE19
    end else begin
      upper_erase_block_select <= next_uebs;
      if (wr_ctrl) begin
        software_write_enable <= wb_dat_i[`FBS_CTRL_WREN];
      end
      if (wr_rovl) begin
        ram_overlay_control <= wb_dat_i[5:0]; // RULE4 RULE10
      end
    end
  end

  // Read mux on the byte address; unmapped addresses return zero.
  always @* begin
    rd_byte = 8'h00;
    case (wb_adr_i)
      `FBS_ADR_CTRL: rd_byte = ctrl_rd;
      `FBS_ADR_UEBS: rd_byte = uebs_rd; // RULE3
      `FBS_ADR_ROVL: rd_byte = rovl_rd; // RULE3
      `FBS_ADR_STAT: rd_byte = stat_rd; // RULE17
      default: rd_byte = 8'h00;
    endcase
  end

  // Single-cycle acknowledge for every address. A request is not taken again while
  // its own ack stands, so a master that holds stb for the ack cycle is answered once.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Loader sequencing for boot mode. The start-up wait stands in for the serial rate
  // search; load and erase end on handshakes from the loader helpers.
  always @* begin
    next_bt_state = bt_state;
    case (bt_state)
      BT_IDLE: if (mode == `FBS_MODE_BOOT) next_bt_state = BT_WAIT; // RULE14
      BT_WAIT: if (bt_cnt == `FBS_BOOT_WAIT) next_bt_state = BT_LOAD;
      BT_LOAD: if (boot_load_done_i) next_bt_state = BT_ERASE;
      BT_ERASE: if (boot_erase_done_i) next_bt_state = BT_RUN;
      BT_RUN: next_bt_state = BT_RUN;
      default: next_bt_state = BT_IDLE;
    endcase
  end

  // Loader state register and wait counter; the counter idles at zero outside the
  // wait, so a second boot-mode reset starts a full wait again.
  always @(posedge clk_i) begin
    if (rst_i) begin
      bt_state <= BT_IDLE;
      bt_cnt <= 8'h00;
    end else begin
      bt_state <= next_bt_state;
      bt_cnt <= (bt_state == BT_WAIT) ? bt_cnt + 8'h01 : 8'h00;
    end
  end

  // Registered flash-side outputs; each follows its source one cycle late, which
  // the flash sequencer must allow for.
  always @(posedge clk_i) begin
    if (rst_i) begin
      erase_blk_nine_o <= 1'b0;
      erase_blk_eight_o <= 1'b0;
      erase_lo_o <= 24'h000000;
      erase_hi_o <= 24'h000000;
      pe_allow_o <= 1'b0;
      overlay_active_o <= 1'b0;
      overlay_flash_base_o <= 24'h000000;
      overlay_ram_lo_o <= 24'h000000;
      overlay_ram_hi_o <= 24'h000000;
      boot_erase_all_o <= 1'b0;
      boot_run_o <= 1'b0;
      mode_o <= `FBS_MODE_NONE;
    end else begin
      erase_blk_nine_o <= upper_erase_block_select[`FBS_UEBS_NINE];
      erase_blk_eight_o <= upper_erase_block_select[`FBS_UEBS_EIGHT];
      // The select register never holds two bits, so only one region is ever shown.
      erase_lo_o <= region_lo(upper_erase_block_select); // RULE5 RULE6
      erase_hi_o <= region_hi(upper_erase_block_select); // RULE5 RULE6
      // Program and erase need the enable bit and a mode that owns the flash, or the
      // loader's own erase phase. While the overlay is on every block is locked,
      // whatever the select register holds; the select itself is left as written.
      pe_allow_o <= software_write_enable & ~overlay_enable &
        (mode_writable(mode) | (bt_state == BT_ERASE)); // RULE7 RULE15 RULE16
      overlay_active_o <= overlay_enable; // RULE7
      overlay_flash_base_o <= area_base({overlay_area_bit_two, overlay_area_bit_one}); // RULE9
      // The RAM window is fixed. The mapping moves one cycle after a register write,
      // so software must leave a gap before it touches the emulated area again.
      overlay_ram_lo_o <= overlay_enable ? `FBS_RAM_LO : 24'h000000; // RULE8
      overlay_ram_hi_o <= overlay_enable ? `FBS_RAM_HI : 24'h000000; // RULE8
      boot_erase_all_o <= (bt_state == BT_ERASE); // RULE14
      boot_run_o <= (bt_state == BT_RUN);
      mode_o <= mode;
    end
  end
endmodule // fbs_ctrl

// ===== rtl/fbs_map.vh
`ifndef FBS_MAP_VH
`define FBS_MAP_VH
// Register byte addresses on the bus.
`define FBS_ADR_CTRL 4'h0
`define FBS_ADR_UEBS 4'h4
`define FBS_ADR_ROVL 4'h8
`define FBS_ADR_STAT 4'hC
// Control register fields.
`define FBS_CTRL_WREN 0
// Upper erase-block select fields.
`define FBS_UEBS_NINE 1
`define FBS_UEBS_EIGHT 0
// Overlay register fields.
`define FBS_ROVL_EN 3
`define FBS_ROVL_AREA_HI 2
`define FBS_ROVL_AREA_LO 1
// Status register fields.
`define FBS_STAT_PIN 0
`define FBS_STAT_MODE_LO 1
`define FBS_STAT_MODE_HI 2
`define FBS_STAT_PROT 3
`define FBS_STAT_BUSY 4
// Reset values.
`define FBS_UEBS_RST 8'h00
`define FBS_ROVL_RST 8'h00
// Erase regions of the two upper blocks.
`define FBS_NINE_LO 24'h018000
`define FBS_NINE_HI 24'h01FFFF
`define FBS_EIGHT_LO 24'h010000
`define FBS_EIGHT_HI 24'h017FFF
// Overlay RAM window and flash block bases.
`define FBS_RAM_LO 24'hFFE000
`define FBS_RAM_HI 24'hFFE3FF
`define FBS_OVL_STEP 24'h000400
// Operating modes.
`define FBS_MODE_NONE 2'h0
`define FBS_MODE_USER 2'h1
`define FBS_MODE_BOOT 2'h2
`define FBS_MODE_UPGM 2'h3
// Mode pin patterns, order mode_pin_two..zero then write enable pin.
`define FBS_PAT_USER 4'hF
`define FBS_PAT_BOOT 4'h7
// Boot loader sequencing counts in cycles.
`define FBS_BOOT_WAIT 8'h64
`endif

// ===== rtl/fbs_mode_latch.v
`timescale 1ns/1ps
`include "fbs_map.vh"
module fbs_mode_latch (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Mode pins and the flash write enable pin.
  input wire mode_pin_two_i,
  input wire mode_pin_one_i,
  input wire mode_pin_zero_i,
  input wire flash_write_enable_pin_i,
  // Latched operating mode.
  output reg [1:0] mode_o
);
  reg in_reset;
  wire [3:0] pat;

  // Pin pattern seen in the cycle of reset release.
  assign pat = {mode_pin_two_i, mode_pin_one_i, mode_pin_zero_i, flash_write_enable_pin_i};

  // Mode is caught at the first clock after reset and then held.
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_reset <= 1'b1;
      mode_o <= `FBS_MODE_NONE;
    end else begin
      in_reset <= 1'b0;
      if (in_reset) begin // RULE18
        case (pat) // RULE13
          `FBS_PAT_USER: mode_o <= `FBS_MODE_USER;
          `FBS_PAT_BOOT: mode_o <= `FBS_MODE_BOOT;
          default: mode_o <= `FBS_MODE_NONE;
        endcase
      end
    end
  end
endmodule // fbs_mode_latch

// ===== tb/fbs_ctrl_assertions.sv
`timescale 1ns/1ps
// Watches the bus handshake and the flash-side outputs of the control block.
module fbs_ctrl_assertions (
  // Clock, reset and bus.
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  // Flash side.
  input logic erase_blk_nine_o,
  input logic erase_blk_eight_o,
  input logic [23:0] erase_lo_o,
  input logic [23:0] erase_hi_o,
  input logic pe_allow_o,
  input logic overlay_active_o,
  input logic [23:0] overlay_flash_base_o,
  input logic [23:0] overlay_ram_lo_o,
  input logic [23:0] overlay_ram_hi_o,
  input logic [1:0] mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A taken request is answered next cycle by a one-cycle acknowledge.
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_answer_a: assert property (req_s |=> ans_s) else $error("bad bus answer");
  one_select_a: assert property (!(erase_blk_nine_o && erase_blk_eight_o)) else $error("two selects");
  upper_region_a: assert property (erase_blk_nine_o |->
    erase_lo_o == 24'h018000 && erase_hi_o == 24'h01FFFF) else $error("upper region");
  lower_region_a: assert property (erase_blk_eight_o |->
    erase_lo_o == 24'h010000 && erase_hi_o == 24'h017FFF) else $error("lower region");
  overlay_protect_a: assert property (overlay_active_o |-> !pe_allow_o) else $error("no protect");
  ram_window_a: assert property (overlay_active_o |->
    overlay_ram_lo_o == 24'hFFE000 && overlay_ram_hi_o == 24'hFFE3FF) else $error("ram window");
  block_base_a: assert property (overlay_flash_base_o[9:0] == 10'h000 &&
    overlay_flash_base_o[23:12] == 12'h000) else $error("block base");
  mode_hold_a: assert property (mode_o != 2'h0 |=> $stable(mode_o)) else $error("mode moved");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
    !erase_blk_nine_o && !erase_blk_eight_o && !overlay_active_o) else $error("reset");
endmodule // fbs_ctrl_assertions

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "fbs_map.vh"
// Drives the control block over the register bus and checks its outputs.
module testbench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, ld = 1'b0, ed = 1'b0;
  reg [3:0] adr = 4'h0, pins = 4'hF;
  reg [31:0] dat = 32'h0, q;
  wire [31:0] rdat;
  wire ack, sel_nine, sel_eight, pea, ova, ber, brun;
  wire [23:0] elo, ehi, obase, rlo, rhi;
  wire [1:0] mode;
  integer n_mismatch = 0, checks = 0, i, n;
  fbs_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mode_pin_two_i(pins[3]), .mode_pin_one_i(pins[2]), .mode_pin_zero_i(pins[1]),
    .flash_write_enable_pin_i(pins[0]), .boot_load_done_i(ld), .boot_erase_done_i(ed),
    .erase_blk_nine_o(sel_nine), .erase_blk_eight_o(sel_eight), .erase_lo_o(elo), .erase_hi_o(ehi),
    .pe_allow_o(pea), .overlay_active_o(ova), .overlay_flash_base_o(obase),
    .overlay_ram_lo_o(rlo), .overlay_ram_hi_o(rhi), .boot_erase_all_o(ber), .boot_run_o(brun),
    .mode_o(mode));
  // Clock at 250 MHz.
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Compares a seen value with the expected one.
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  // One classic bus cycle, entered just after a rising edge; read data lands in q.
  task xfer(input w, input [3:0] a, input [31:0] d);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50) begin
        @(posedge clk_i);
        n = n + 1;
      end
      q = rdat;
      if (n == 50) chk(32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rd(input [3:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      chk(q, exp);
    end
  endtask
  // Resets with the given pin pattern held throughout.
  task reset_to(input [3:0] p);
    begin
      pins <= p;
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task conclude;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Cuts a hang short.
  initial begin
    #80000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  // Main sequence.
  initial begin
    @(posedge clk_i);
    reset_to(4'hF);
    rd(`FBS_ADR_STAT, 32'h03);
    rd(`FBS_ADR_UEBS, 32'h0);
    rd(`FBS_ADR_ROVL, 32'h0);
    rd(4'h2, 32'h0);
    xfer(1'b1, `FBS_ADR_UEBS, 32'h2);
    rd(`FBS_ADR_UEBS, 32'h0);
    chk(pea, 32'h0);
    xfer(1'b1, `FBS_ADR_CTRL, 32'h1);
    xfer(1'b1, `FBS_ADR_UEBS, 32'hFF);
    rd(`FBS_ADR_UEBS, 32'h0);
    xfer(1'b1, `FBS_ADR_UEBS, 32'hFE);
    rd(`FBS_ADR_UEBS, 32'h2);
    chk({sel_nine, elo, ehi}, {1'b1, 24'h018000, 24'h01FFFF});
    chk(pea, 32'h1);
    xfer(1'b1, `FBS_ADR_UEBS, 32'h1);
    rd(`FBS_ADR_UEBS, 32'h1);
    chk({sel_eight, elo, ehi}, {1'b1, 24'h010000, 24'h017FFF});
    xfer(1'b1, `FBS_ADR_CTRL, 32'h0);
    rd(`FBS_ADR_UEBS, 32'h0);
    xfer(1'b1, `FBS_ADR_CTRL, 32'h1);
    $display("test select done");
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1'b1, `FBS_ADR_ROVL, 32'h9 | (i << 1));
      rd(`FBS_ADR_ROVL, 32'h9 | (i << 1));
      chk(obase, i * 32'h400);
      chk({ova, pea, rlo, rhi}, {2'b10, 24'hFFE000, 24'hFFE3FF});
    end
    xfer(1'b1, `FBS_ADR_ROVL, 32'hC0);
    rd(`FBS_ADR_ROVL, 32'h0);
    pins <= 4'h0;
    rd(`FBS_ADR_STAT, 32'h02);
    $display("test overlay done");
    reset_to(4'h7);
    chk(mode, 32'h2);
    xfer(1'b1, `FBS_ADR_ROVL, 32'h8);
    rd(`FBS_ADR_ROVL, 32'h0);
    ld <= 1'b1;
    for (n = 0; n < 300 && ber !== 1'b1; n = n + 1) @(posedge clk_i);
    chk(ber, 32'h1);
    ed <= 1'b1;
    for (n = 0; n < 300 && brun !== 1'b1; n = n + 1) @(posedge clk_i);
    chk(brun, 32'h1);
    $display("test boot done");
    conclude;
  end
endmodule // testbench
bind fbs_ctrl fbs_ctrl_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .erase_blk_nine_o(erase_blk_nine_o),
  .erase_blk_eight_o(erase_blk_eight_o), .erase_lo_o(erase_lo_o), .erase_hi_o(erase_hi_o),
  .pe_allow_o(pe_allow_o), .overlay_active_o(overlay_active_o),
  .overlay_flash_base_o(overlay_flash_base_o), .overlay_ram_lo_o(overlay_ram_lo_o),
  .overlay_ram_hi_o(overlay_ram_hi_o), .mode_o(mode_o));
